// file: logic/cpu_bus_pkg.sv
// constants, cycle kinds, segment selects and bus states for the
// minimum-mode bus control block; assumes a single 100 MHz clock domain
package cpu_bus_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int SEG_SHIFT = 4;
	localparam int QUEUE_DEPTH = 5;
	localparam int COUNT_W = 3;
	localparam int VEC_TYPE_W = 8;
	localparam int VEC_ENTRY_W = 2;
	localparam int VEC_PAD_W = ADDR_W - VEC_TYPE_W - VEC_ENTRY_W;
	localparam logic [15:0] RESET_SEGMENT = 16'hF000;
	localparam logic [15:0] RESET_OFFSET = 16'hFFF0;
	localparam logic [19:0] VECTOR_TABLE_BASE = 20'h0_0000;
	localparam logic [COUNT_W-1:0] QUEUE_FULL = 3'h5;
	localparam logic [COUNT_W-1:0] QUEUE_EMPTY = 3'h0;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 3'h1;
	localparam logic [15:0] IP_STEP = 16'h0001;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [19:0] ADDR_ZERO = 20'h0_0000;

	typedef enum logic [1:0] {
		SEG_CODE, SEG_STACK, SEG_DATA, SEG_EXTRA
	} seg_sel_type;

	typedef enum logic [2:0] {
		CYC_MEM_READ, CYC_MEM_WRITE, CYC_IO_READ, CYC_IO_WRITE,
		CYC_IRQ_ACK, CYC_VECTOR_READ
	} cycle_kind_type;

	typedef enum logic [2:0] {
		ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HOLD
	} bus_state_type;
endpackage

// file: logic/cpu_min_mode_bus_control.sv
// minimum-mode bus control: strobes, hold handshake, address forming
// and the instruction prefetch queue; each T-state is two clocks, so
// "middle of" a state is the edge between its two clocks; all inputs
// are taken as synchronous to clk
module cpu_min_mode_bus_control (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// strap
	input wire logic config_mode_strap,
	// execution unit request
	input wire logic req_valid,
	input wire cpu_bus_pkg::cycle_kind_type req_kind,
	input wire cpu_bus_pkg::seg_sel_type req_seg,
	input wire logic req_stack_ref,
	input wire logic req_string_dest,
	input wire logic [15:0] req_offset,
	input wire logic [7:0] req_vector_type,
	input wire logic [15:0] req_wdata,
	input wire logic req_odd_low,
	input wire logic req_first_ack,
	input wire logic req_locked,
	output logic req_done,
	output logic [15:0] req_rdata,
	// segment bases
	input wire logic [15:0] code_segment_base,
	input wire logic [15:0] stack_segment_base,
	input wire logic [15:0] data_segment_base,
	input wire logic [15:0] extra_segment_base,
	// instruction queue
	input wire logic queue_pop,
	input wire logic queue_flush,
	input wire logic [15:0] flush_ip,
	output logic queue_valid,
	output logic [7:0] queue_byte,
	// local bus
	input wire logic [15:0] ad_in,
	output logic [15:0] ad_out,
	output logic ad_oe,
	output logic [3:0] addr_high,
	output logic addr_high_oe,
	input wire logic ready,
	// bus control strobes
	output logic addr_latch_en,
	output logic mem_io_sel,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic irq_ack_strobe_n,
	output logic xcvr_direction,
	output logic xcvr_enable_n,
	output logic ctrl_oe,
	// hold handshake
	input wire logic hold_request,
	output logic bus_hold_grant
);
	import cpu_bus_pkg::*;

	bus_state_type state_q, state_d;
	logic phase_q, phase_d, grant_q, grant_d, launch;
	logic min_mode_q, boot_q, discard_q, early_q, oe_q;
	logic fetch_q, odd_low_q, first_ack_q, locked_q;
	cycle_kind_type kind_q;
	logic [19:0] addr_q;
	logic [15:0] wdata_q, ip_q, rdata_q;
	logic done_q, qvalid_q;
	logic [7:0] q_q [QUEUE_DEPTH];
	logic [7:0] q_d [QUEUE_DEPTH];
	logic [COUNT_W-1:0] count_q, count_d;
	logic ale_q, mio_q, rd_n_q, wr_n_q, ack_n_q, dir_q, den_n_q;
	logic [15:0] ad_q;
	logic ad_oe_q;

	// request selection, executor first
	wire want_eu = req_valid && !done_q;
	wire want_fetch = count_q < QUEUE_FULL;
	wire want_any = min_mode_q && (want_eu || want_fetch);
	wire take_eu = want_eu;

	// segment choice
	wire seg_sel_type seg_pick = req_string_dest ? SEG_EXTRA :
		req_stack_ref ? SEG_STACK : req_seg;
	wire [15:0] eu_base = (seg_pick == SEG_CODE) ? code_segment_base :
		(seg_pick == SEG_STACK) ? stack_segment_base :
		(seg_pick == SEG_DATA) ? data_segment_base : extra_segment_base;
	wire [15:0] fetch_base = boot_q ? RESET_SEGMENT :
		code_segment_base;
	wire [15:0] pick_base = take_eu ? eu_base : fetch_base;
	wire [15:0] pick_off = take_eu ? req_offset : ip_q;

	// physical address forming
	wire [19:0] seg_addr = {pick_base, {SEG_SHIFT{1'b0}}} +
		{{SEG_SHIFT{1'b0}}, pick_off};
	wire [19:0] vec_addr = VECTOR_TABLE_BASE | {{VEC_PAD_W{1'b0}},
		req_vector_type, req_offset[VEC_ENTRY_W-1:0]};
	wire is_vec = take_eu && (req_kind == CYC_VECTOR_READ);
	wire [19:0] new_addr = is_vec ? vec_addr : seg_addr;
	wire cycle_kind_type new_kind = take_eu ? req_kind : CYC_MEM_READ;

	// kind of the cycle being driven next
	wire cycle_kind_type kind_d = launch ? new_kind : kind_q;
	wire is_wr = (kind_d == CYC_MEM_WRITE) || (kind_d == CYC_IO_WRITE);
	wire is_ack = kind_d == CYC_IRQ_ACK;
	wire is_io = (kind_d == CYC_IO_READ) || (kind_d == CYC_IO_WRITE) ||
		is_ack;
	wire is_rd = !is_wr && !is_ack;
	wire in_mid = (state_d == ST_T2) || (state_d == ST_T3) ||
		(state_d == ST_TW);
	wire t4_first = (state_d == ST_T4) && !phase_d;
	wire t2_second = (state_d == ST_T2) && phase_d;

	// release conditions at T4
	wire release_ok = hold_request && early_q && !odd_low_q &&
		!first_ack_q && !locked_q;
	wire data_end = ((state_q == ST_T3) || (state_q == ST_TW)) &&
		phase_q && ready;
	wire push = data_end && fetch_q && !discard_q && !queue_flush;
	wire pop = queue_pop && (count_q != QUEUE_EMPTY);
	wire [7:0] fetch_byte = ip_q[0] ? ad_in[15:8] : ad_in[7:0];

	// bus state sequencing
	always_comb begin
		state_d = state_q;
		phase_d = !phase_q;
		grant_d = grant_q;
		launch = 1'b0;
		case (state_q)
			ST_IDLE: begin
				phase_d = 1'b0;
				if (hold_request) begin
					state_d = ST_HOLD;
					grant_d = 1'b1;
				end else if (want_any) begin
					state_d = ST_T1;
					launch = 1'b1;
				end
			end
			ST_T1: if (phase_q) state_d = ST_T2;
			ST_T2: if (phase_q) state_d = ST_T3;
			ST_T3, ST_TW: if (phase_q) state_d = ready ? ST_T4 : ST_TW;
			ST_T4: begin
				if (!phase_q) begin
					if (release_ok) grant_d = 1'b1;
				end else if (grant_q) begin
					state_d = hold_request ? ST_HOLD : ST_IDLE;
					grant_d = hold_request;
				end else if (want_any && !hold_request) begin
					state_d = ST_T1;
					launch = 1'b1;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_HOLD: begin
				phase_d = 1'b0;
				if (!hold_request) begin
					grant_d = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// driving returns only with a new cycle, drops with grant
	wire oe_d = min_mode_q && !grant_d && (launch || oe_q);

	// queue shift with pop then push
	always_comb begin
		count_d = count_q - (pop ? COUNT_ONE : QUEUE_EMPTY);
		for (int i = 0; i < QUEUE_DEPTH; i++) begin
			q_d[i] = q_q[i];
			if (pop && i < QUEUE_DEPTH - 1) q_d[i] = q_q[i + 1];
		end
		if (push) begin
			q_d[count_d] = fetch_byte;
			count_d = count_d + COUNT_ONE;
		end
		if (queue_flush) count_d = QUEUE_EMPTY;
	end

	// state, grant and cycle registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			phase_q <= 1'b0;
			grant_q <= 1'b0;
			oe_q <= 1'b0;
			min_mode_q <= config_mode_strap;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			grant_q <= grant_d;
			oe_q <= oe_d;
		end
	end

	// captured attributes of the running cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			kind_q <= CYC_MEM_READ;
			addr_q <= ADDR_ZERO;
			wdata_q <= WORD_ZERO;
			{fetch_q, odd_low_q, first_ack_q, locked_q} <= '0;
		end else if (launch) begin
			kind_q <= new_kind;
			addr_q <= new_addr;
			wdata_q <= req_wdata;
			fetch_q <= !take_eu;
			odd_low_q <= take_eu && req_odd_low;
			first_ack_q <= take_eu && req_first_ack;
			locked_q <= take_eu && req_locked;
		end
	end

	// early request tracking, set seen on or before T2
	always_ff @(posedge clk) begin
		if (!reset_n || launch) begin
			early_q <= 1'b0;
		end else if ((state_q == ST_T1 || state_q == ST_T2) &&
			hold_request) begin
			early_q <= 1'b1;
		end
	end

	// instruction pointer, boot vector and flush discard
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ip_q <= RESET_OFFSET;
			boot_q <= 1'b1;
			discard_q <= 1'b0;
		end else if (queue_flush) begin
			ip_q <= flush_ip;
			boot_q <= 1'b0;
			discard_q <= launch ? !take_eu : (fetch_q &&
				state_q != ST_IDLE && state_q != ST_HOLD);
		end else begin
			if (push) ip_q <= ip_q + IP_STEP;
			if (launch) discard_q <= 1'b0;
		end
	end

	// prefetch queue storage
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count_q <= QUEUE_EMPTY;
			qvalid_q <= 1'b0;
			for (int i = 0; i < QUEUE_DEPTH; i++) q_q[i] <= BYTE_ZERO;
		end else begin
			count_q <= count_d;
			qvalid_q <= count_d != QUEUE_EMPTY;
			q_q <= q_d;
		end
	end

	// executor answer
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			done_q <= 1'b0;
			rdata_q <= WORD_ZERO;
		end else begin
			done_q <= data_end && !fetch_q;
			if (data_end && !fetch_q) rdata_q <= ad_in;
		end
	end

	// registered strobes derived from the next bus state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ale_q <= 1'b0;
			{mio_q, dir_q} <= '0;
			{rd_n_q, wr_n_q, ack_n_q, den_n_q} <= '1;
			ad_q <= WORD_ZERO;
			ad_oe_q <= 1'b0;
		end else begin
			ale_q <= min_mode_q && state_d == ST_T1 && !phase_d;
			if (launch) mio_q <= !is_io;
			if (launch) dir_q <= is_wr;
			rd_n_q <= !(in_mid && is_rd);
			wr_n_q <= !(in_mid && is_wr);
			ack_n_q <= !(in_mid && is_ack);
			den_n_q <= !(is_wr ? (in_mid || t4_first) :
				(t2_second || (in_mid && state_d != ST_T2) ||
				t4_first));
			ad_q <= (state_d == ST_T1) ? (launch ? new_addr[15:0] :
				addr_q[15:0]) : wdata_q;
			ad_oe_q <= oe_d && (state_d == ST_T1 ||
				(is_wr && (in_mid || t4_first)));
		end
	end

	// outputs
	assign addr_latch_en = ale_q;
	assign mem_io_sel = mio_q;
	assign read_strobe_n = rd_n_q;
	assign write_strobe_n = wr_n_q;
	assign irq_ack_strobe_n = ack_n_q;
	assign xcvr_direction = dir_q;
	assign xcvr_enable_n = den_n_q;
	assign ctrl_oe = oe_q;
	assign ad_out = ad_q;
	assign ad_oe = ad_oe_q;
	assign addr_high = addr_q[19:16];
	assign addr_high_oe = oe_q;
	assign bus_hold_grant = grant_q;
	assign req_done = done_q;
	assign req_rdata = rdata_q;
	assign queue_valid = qvalid_q;
	assign queue_byte = q_q[0];
endmodule

// file: test/cpu_min_mode_bus_control_properties.sv
// bus strobe and hold handshake checks of the bus control block;
// bound from the bench, sees only the top module's ports
module cpu_bus_properties (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// strobes
	input wire logic addr_latch_en,
	input wire logic mem_io_sel,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic irq_ack_strobe_n,
	input wire logic xcvr_direction,
	input wire logic xcvr_enable_n,
	input wire logic ctrl_oe,
	input wire logic ad_oe,
	// hold
	input wire logic hold_request,
	input wire logic bus_hold_grant
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// strobe shapes and transceiver timing
	a_ale_one_clock: assert property (addr_latch_en |=> !addr_latch_en)
		else $error("ale too long");
	a_write_t2_t3: assert property ($fell(write_strobe_n) |-> $past(addr_latch_en, 2) ##0 !write_strobe_n [*4])
		else $error("write strobe");
	a_read_t2_t3: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*4])
		else $error("read strobe");
	a_ack_t2_t3: assert property ($fell(irq_ack_strobe_n) |-> !mem_io_sel ##0 !irq_ack_strobe_n [*4])
		else $error("ack strobe");
	a_write_enable: assert property ($fell(write_strobe_n) |-> $fell(xcvr_enable_n) && xcvr_direction)
		else $error("write enable");
	a_read_enable: assert property ($fell(read_strobe_n) || $fell(irq_ack_strobe_n) |-> xcvr_enable_n && !xcvr_direction ##1 !xcvr_enable_n)
		else $error("read enable");
	a_enable_span: assert property ($fell(xcvr_enable_n) |-> ##[4:21] $rose(xcvr_enable_n))
		else $error("enable span");
	// hold handshake
	a_grant_floats: assert property ($rose(bus_hold_grant) |-> $past(hold_request) && !ctrl_oe && !ad_oe)
		else $error("grant float");
	a_grant_drop: assert property (bus_hold_grant && !hold_request |=> !bus_hold_grant)
		else $error("grant drop");
	a_hold_quiet: assert property (bus_hold_grant |-> !addr_latch_en && !ctrl_oe)
		else $error("hold quiet");
	// main scenarios
	c_write: cover property ($fell(write_strobe_n));
	c_ack: cover property ($fell(irq_ack_strobe_n));
	c_grant: cover property ($rose(bus_hold_grant));
endmodule

// file: test/bus_memory_model.sv
// memory and i/o on the local bus; read data is the address xor 5a5a so
// the bench can predict it; slow stretches ready to force wait states
module bus_memory_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic addr_latch_en,
	input wire logic [15:0] ad_out,
	input wire logic [3:0] addr_high,
	input wire logic read_strobe_n,
	input wire logic irq_ack_strobe_n,
	input wire logic write_strobe_n,
	output logic [15:0] ad_in,
	output logic ready,
	output logic [19:0] last_addr,
	output logic [15:0] last_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt = 3'h0;
	wire rd = !read_strobe_n || !irq_ack_strobe_n;
	initial ad_in = 16'h0000;
	// latch address, take write data, answer or show a changing bus
	always @(posedge clk) begin
		if (addr_latch_en)
			last_addr <= {addr_high, ad_out};
		if (!write_strobe_n)
			last_wdata <= ad_out;
		cnt <= (rd || !write_strobe_n) ? cnt + 3'h1 : 3'h0;
		ad_in <= rd ? last_addr[15:0] ^ 16'h5a5a : ~ad_in;
	end
	assign ready = !slow || cnt > 3'h4;
endmodule

// file: test/cpu_min_mode_bus_control_bench.sv
// self-checking bench for the bus control block; a memory model
// answers on the local bus and the checker is bound to the block
module cpu_min_mode_bus_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cpu_bus_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, config_mode_strap = 1'b1;
	logic req_valid = 1'b0, req_stack_ref = 1'b0, req_string_dest = 1'b0;
	logic req_locked = 1'b0, queue_pop = 1'b0, hold_request = 1'b0;
	logic req_odd_low = 1'b0, req_first_ack = 1'b0, queue_flush = 1'b0;
	logic [15:0] flush_ip = 16'h0000;
	logic slow = 1'b0, mio;
	cycle_kind_type req_kind = CYC_MEM_READ;
	seg_sel_type req_seg = SEG_DATA;
	logic [15:0] req_offset = 16'h0000, req_wdata = 16'hbeef;
	logic [7:0] req_vector_type = 8'h00;
	logic [15:0] bases [4] = '{16'h1234, 16'h3000, 16'h4abc, 16'h3000};
	logic req_done, queue_valid, ad_oe, addr_high_oe, ready, addr_latch_en;
	logic mem_io_sel, read_strobe_n, write_strobe_n, irq_ack_strobe_n;
	logic xcvr_direction, xcvr_enable_n, ctrl_oe, bus_hold_grant;
	logic [15:0] req_rdata, ad_in, ad_out, last_wdata;
	logic [7:0] queue_byte;
	logic [3:0] addr_high;
	logic [19:0] last_addr;
	int err_total = 0, check_count = 0, lat;
	cpu_min_mode_bus_control dut (.clk, .reset_n, .config_mode_strap,
		.req_valid, .req_kind, .req_seg, .req_stack_ref, .req_string_dest,
		.req_offset, .req_vector_type, .req_wdata, .req_odd_low,
		.req_first_ack, .req_locked, .req_done, .req_rdata,
		.code_segment_base(16'h2000), .stack_segment_base(bases[1]),
		.data_segment_base(bases[0]), .extra_segment_base(bases[2]),
		.queue_pop, .queue_flush, .flush_ip, .queue_valid,
		.queue_byte, .ad_in, .ad_out, .ad_oe, .addr_high, .addr_high_oe,
		.ready, .addr_latch_en, .mem_io_sel, .read_strobe_n,
		.write_strobe_n, .irq_ack_strobe_n, .xcvr_direction,
		.xcvr_enable_n, .ctrl_oe, .hold_request, .bus_hold_grant);
	bus_memory_model mem (.clk, .slow, .addr_latch_en, .ad_out,
		.addr_high, .read_strobe_n, .irq_ack_strobe_n, .write_strobe_n,
		.ad_in, .ready, .last_addr, .last_wdata);
	// clock and watchdog
	initial forever #5 clk = ~clk;
	initial begin
		#20000;
		err_total++;
		complete_run();
	end
	task automatic complete_run();
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one executor request, held until done, latency counted
	task automatic run(input cycle_kind_type k, input logic [15:0] off,
		input logic sr, input logic sd);
		@(negedge clk);
		req_kind = k;
		req_offset = off;
		req_stack_ref = sr;
		req_string_dest = sd;
		req_valid = 1'b1;
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (req_done !== 1'b1 && lat < 60);
		chk(20'(req_done), 20'h0_0001);
		mio = mem_io_sel;
		req_valid = 1'b0;
	endtask
	task automatic t_write();
		req_seg = SEG_DATA;
		run(CYC_MEM_WRITE, 16'h0010, 1'b0, 1'b0);
		chk(20'(lat), 20'h0_0007);
		chk(last_addr, 20'h1_2350);
		chk(20'(last_wdata), 20'h0_beef);
		chk(20'(mio), 20'h0_0001);
	endtask
	task automatic t_queue();
		logic [15:0] d;
		int i;
		for (i = 0; i < 8 && queue_valid === 1'b1; i++) begin
			d = (16'hfff0 + 16'(i)) ^ 16'h5a5a;
			chk(20'(queue_byte), 20'(i[0] ? d[15:8] : d[7:0]));
			queue_pop = 1'b1;
			@(negedge clk);
		end
		queue_pop = 1'b0;
		chk(20'(i), 20'h0_0005);
	endtask
	task automatic t_segments();
		logic [19:0] a;
		int j;
		for (j = 0; j < 4; j++) begin
			req_seg = (j == 3) ? SEG_STACK : SEG_DATA;
			run(CYC_MEM_READ, 16'h0004, 1'(j == 1), 1'(j == 2));
			a = {bases[j], 4'h0} + 20'h0_0004;
			chk(last_addr, a);
			chk(20'(req_rdata), 20'(a[15:0] ^ 16'h5a5a));
		end
	endtask
	task automatic t_io_ack();
		slow = 1'b1;
		run(CYC_IO_READ, 16'h0080, 1'b0, 1'b0);
		slow = 1'b0;
		chk(20'(lat), 20'h0_0009);
		chk(20'(mio), 20'h0_0000);
		chk(20'(req_rdata), 20'(last_addr[15:0] ^ 16'h5a5a));
		run(CYC_IRQ_ACK, 16'h0000, 1'b0, 1'b0);
		chk(20'(req_rdata), 20'(last_addr[15:0] ^ 16'h5a5a));
		req_vector_type = 8'hff;
		run(CYC_VECTOR_READ, 16'h0002, 1'b0, 1'b0);
		chk(last_addr, 20'h0_03fe);
	endtask
	// flush restarts prefetch at a new pointer in the code segment
	task automatic t_flush();
		queue_flush = 1'b1;
		flush_ip = 16'h0123;
		@(negedge clk);
		queue_flush = 1'b0;
		repeat (60) @(negedge clk);
		chk(20'(queue_byte), 20'h0_005b);
		queue_pop = 1'b1;
		@(negedge clk);
		queue_pop = 1'b0;
		chk(20'(queue_byte), 20'h0_007e);
	endtask
	// hold raised in T1 of a read, with each release blocker in turn
	task automatic t_hold(input logic [2:0] blk);
		logic [4:0] lines;
		repeat (60) @(negedge clk);
		{req_locked, req_odd_low, req_first_ack} = blk;
		fork
			run(CYC_MEM_READ, 16'h0000, 1'b0, 1'b0);
			begin
				@(posedge addr_latch_en);
				@(negedge clk);
				hold_request = 1'b1;
			end
		join
		@(negedge clk);
		chk(20'(bus_hold_grant), 20'(blk == 3'h0));
		repeat (4) @(negedge clk);
		lines = {bus_hold_grant, ctrl_oe, ad_oe, addr_high_oe,
			addr_latch_en};
		chk(20'(lines), 20'h0_0010);
		hold_request = 1'b0;
		@(negedge clk);
		chk(20'(bus_hold_grant), 20'h0_0000);
		{req_locked, req_odd_low, req_first_ack} = 3'h0;
	endtask
	task automatic t_maxmode();
		int seen;
		seen = 0;
		reset_n = 1'b0;
		config_mode_strap = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		repeat (40) begin
			@(negedge clk);
			seen += int'(addr_latch_en);
		end
		chk(20'(seen), 20'h0_0000);
		reset_n = 1'b0;
		config_mode_strap = 1'b1;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		chk({addr_high, ad_out}, 20'hf_fff0);
	endtask
	// main sequence
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		repeat (80) @(negedge clk);
		t_write();
		t_queue();
		t_segments();
		t_io_ack();
		t_flush();
		t_hold(3'h0);
		t_hold(3'h4);
		t_hold(3'h2);
		t_hold(3'h1);
		t_maxmode();
		complete_run();
	end
endmodule
bind cpu_min_mode_bus_control cpu_bus_properties props (.clk, .reset_n,
	.addr_latch_en, .mem_io_sel, .read_strobe_n, .write_strobe_n,
	.irq_ack_strobe_n, .xcvr_direction, .xcvr_enable_n, .ctrl_oe, .ad_oe,
	.hold_request, .bus_hold_grant);
